// >>> hw/sps_pkg.sv
// Constants and types shared by the port power-state controller
package sps_pkg;

  // Power state field encodings of the per-port status/control word
  localparam logic [1:0] SPS_PS_D0    = 2'h0;
  localparam logic [1:0] SPS_PS_D1    = 2'h1;
  localparam logic [1:0] SPS_PS_D2    = 2'h2;
  localparam logic [1:0] SPS_PS_D3HOT = 2'h3;

  // Configuration offsets these bits live at in each port's space
  localparam logic [11:0] SPS_CMD_OFFSET   = 12'h004;
  localparam logic [11:0] SPS_PMCSR_OFFSET = 12'h044;

  // Field positions inside those words
  localparam int SPS_PS_LSB       = 0;
  localparam int SPS_PME_EN_BIT   = 8;
  localparam int SPS_CMD_IO_BIT   = 0;
  localparam int SPS_CMD_MEM_BIT  = 1;
  localparam int SPS_CMD_BM_BIT   = 2;
  localparam int SPS_CMD_W        = 3;

  // Reset values
  localparam logic [1:0] SPS_PS_RESET     = 2'h0;
  localparam logic       SPS_PME_ST_RESET = 1'b0;

  // Timing: core clock and hardware-autonomous idle thresholds
  localparam int SPS_CLK_PERIOD_NS = 20;
  localparam int SPS_L0S_IDLE_NS   = 7000;
  localparam int SPS_L1_IDLE_NS    = 20000;
  localparam int SPS_L0S_IDLE_CYC  =
    (SPS_L0S_IDLE_NS + SPS_CLK_PERIOD_NS - 1) / SPS_CLK_PERIOD_NS;
  localparam int SPS_L1_IDLE_CYC   =
    (SPS_L1_IDLE_NS + SPS_CLK_PERIOD_NS - 1) / SPS_CLK_PERIOD_NS;
  localparam int SPS_IDLE_CNT_W    = 11;

  // Device power states of one port
  typedef enum logic [2:0] {
    SPS_D0_UNINIT,
    SPS_D0_ACTIVE,
    SPS_D1,
    SPS_D2,
    SPS_D3HOT
  } sps_dstate_t;

  // Kinds of request presented for acceptance checking
  typedef enum logic [2:0] {
    SPS_REQ_CFG0,
    SPS_REQ_CFG1,
    SPS_REQ_MEM,
    SPS_REQ_IO,
    SPS_REQ_CPL
  } sps_req_t;

endpackage

// >>> hw/sps_wake_fwd.sv
// Auxiliary-powered beacon and wake forwarding for the D3cold state
`timescale 1ns/100ps
module sps_wake_fwd #(
  parameter int NUM_DOWN = 3
) (
  input  wire logic                clock,
  input  wire logic                aux_rst,
  input  wire logic                main_power_good,
  input  wire logic [NUM_DOWN-1:0] beacon_det,
  input  wire logic                wake_n_i,
  output logic                     wake_n_o,
  output logic                     wake_n_oe,
  output logic                     beacon_up,
  output logic                     links_in_l2
);

  // Two-flop synchronisers for every pin input
  logic [NUM_DOWN+1:0] sync1;
  logic [NUM_DOWN+1:0] sync2;
  logic                in_d3cold;
  logic                beacon_any;
  logic                wake_low;

  // Idle pin levels, so aux reset does not fake a D3cold entry
  localparam logic [NUM_DOWN+1:0] SYNC_IDLE = {1'b1, {(NUM_DOWN+1){1'b0}}};

  always_ff @(posedge clock) begin
    if (aux_rst) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= {main_power_good, ~wake_n_i, beacon_det};
      sync2 <= sync1;
    end
  end

  assign in_d3cold  = ~sync2[NUM_DOWN+1];
  assign wake_low   = sync2[NUM_DOWN];
  assign beacon_any = |sync2[NUM_DOWN-1:0];
  assign wake_n_o   = 1'b0;

  // Only this domain runs without main power, so the core reset never
  // touches it [R25]
  always_ff @(posedge clock) begin
    if (aux_rst) begin
      beacon_up   <= 1'b0;
      wake_n_oe   <= 1'b0;
      links_in_l2 <= 1'b0;
    end else begin
      links_in_l2 <= in_d3cold;                            // [R15]
      beacon_up   <= in_d3cold & (beacon_any | wake_low);  // [R16] [R17]
      wake_n_oe   <= in_d3cold & beacon_any;               // [R18]
    end
  end

  // Beacon from below raises both upstream beacon and wake
  sequence s_down_beacon;
    in_d3cold && beacon_any;
  endsequence

  property p_beacon_both;
    @(posedge clock) disable iff (aux_rst)
      s_down_beacon |=> beacon_up && wake_n_oe && !wake_n_o;
  endproperty
  a_beacon_both: assert property (p_beacon_both) // [R16] [R18]
    else $error("downstream beacon not forwarded with wake");

  property p_wake_beacon;
    @(posedge clock) disable iff (aux_rst)
      in_d3cold && wake_low |=> beacon_up;
  endproperty
  a_wake_beacon: assert property (p_wake_beacon) // [R17]
    else $error("wake low did not raise upstream beacon");

  property p_no_beacon_powered;
    @(posedge clock) disable iff (aux_rst)
      !in_d3cold |=> !beacon_up && !wake_n_oe && !links_in_l2;
  endproperty
  a_no_beacon_powered: assert property (p_no_beacon_powered) // [R15]
    else $error("wake signalling while main power is good");

endmodule

// >>> hw/sps_power_ctrl.sv
// Per-port device power-state control for a multi-port switch
// Function
// [R1] Writing 01/10/11 from D0 moves a port into D1, D2 or D3hot.
// [R2] Writing 00 while in D3hot returns the port to D0 uninitialised.
// [R3] Fundamental or later reset places every port in D0 uninitialised.
// [R4] Any command enable bit set moves a port into D0 active.
// [R5] In D1/D2/D3hot type 0 config completes; memory and I/O get UR.
// [R6] Type 1 config toward a low-power port ends as UR.
// [R7] Completions pass unchanged whatever the port's power state.
// [R8] Upstream port in D1 or D2 requests L1 entry on its link.
// [R9] Upstream port in D3hot requests L1 entry on its link.
// [R10] In D1/D2/D3hot hot plug or link change raises a PME.
// [R11] Host sends turn-off; switch forwards it and takes upstream to L2/L3.
// [R12] Ready for D3cold only once every link is in L2/L3 Ready.
// [R13] Host asserts fundamental reset, then removes clock and power.
// [R14] Host stops the reference clock only after fundamental reset.
// [R15] Without main power but with aux, settle in D3cold, links in L2.
// [R16] In D3cold, downstream beacon from L2 drives beacon upstream.
// [R17] In D3cold, wake pin sampled low drives beacon upstream.
// [R18] Downstream beacon wake sends beacon upstream and pulls wake low.
// [R19] System wires its wake line to the switch's two-way wake pin.
// [R20] Host holds fundamental reset 100 ms after power, clocks stable.
// [R21] Only reset changes power state without software asking.
// [R22] Links enter L0s and L1 autonomously when idle, no software.
// [R23] Field encodes 00 D0, 01 D1, 10 D2, 11 D3hot.
// [R24] A port raises PME only while its PME enable bit is set.
// [R25] Beacon and wake logic sit in the aux domain, immune to core reset.
// [R26] During fundamental reset state is held at reset, no link moves.
`timescale 1ns/100ps
module sps_power_ctrl #(
  parameter int NUM_PORTS = 4,
  parameter int PORT_W    = $clog2(NUM_PORTS)
) (
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire logic                              aux_rst,
  input  wire logic                              fundamental_reset_n,
  input  wire logic [NUM_PORTS-1:0]              ps_write,
  input  wire logic [2*NUM_PORTS-1:0]            ps_wdata,
  input  wire logic [sps_pkg::SPS_CMD_W*NUM_PORTS-1:0] cmd_enables,
  input  wire logic [NUM_PORTS-1:0]              pme_enable,
  input  wire logic [NUM_PORTS-1:0]              pme_status_clr,
  input  wire logic [NUM_PORTS-1:0]              hot_plug_event,
  input  wire logic [NUM_PORTS-1:0]              link_state_change,
  input  wire logic                              req_valid,
  input  wire logic [PORT_W-1:0]                 req_port,
  input  wire sps_pkg::sps_req_t                 req_kind,
  input  wire logic                              turn_off_rx,
  input  wire logic [NUM_PORTS-1:0]              link_l23_ready,
  input  wire logic [NUM_PORTS-1:0]              aspm_enable,
  input  wire logic [NUM_PORTS-1:0]              link_idle,
  input  wire logic                              main_power_good,
  input  wire logic [NUM_PORTS-2:0]              beacon_det,
  input  wire logic                              wake_n_i,
  output logic [2*NUM_PORTS-1:0]                 ps_field,
  output logic [NUM_PORTS-1:0]                   d0_active,
  output logic [NUM_PORTS-1:0]                   pme_status,
  output logic                                   pme_pulse,
  output logic                                   resp_valid,
  output logic                                   resp_ur,
  output logic                                   resp_forward,
  output logic                                   up_l1_req,
  output logic                                   turn_off_fwd,
  output logic                                   up_l23_req,
  output logic                                   d3cold_ready,
  output logic [NUM_PORTS-1:0]                   aspm_l0s_req,
  output logic [NUM_PORTS-1:0]                   aspm_l1_req,
  output logic                                   wake_n_o,
  output logic                                   wake_n_oe,
  output logic                                   beacon_up,
  output logic                                   links_in_l2
);

  localparam logic [sps_pkg::SPS_IDLE_CNT_W-1:0] L0S_CYC =
    sps_pkg::SPS_IDLE_CNT_W'(sps_pkg::SPS_L0S_IDLE_CYC);
  localparam logic [sps_pkg::SPS_IDLE_CNT_W-1:0] L1_CYC =
    sps_pkg::SPS_IDLE_CNT_W'(sps_pkg::SPS_L1_IDLE_CYC);

  // Field value read back for a given state
  function automatic logic [1:0] ps_of(input sps_pkg::sps_dstate_t st);
    logic [1:0] f;
    f = sps_pkg::SPS_PS_D0;
    unique case (st)
      sps_pkg::SPS_D1:    f = sps_pkg::SPS_PS_D1;
      sps_pkg::SPS_D2:    f = sps_pkg::SPS_PS_D2;
      sps_pkg::SPS_D3HOT: f = sps_pkg::SPS_PS_D3HOT;
      sps_pkg::SPS_D0_UNINIT,
      sps_pkg::SPS_D0_ACTIVE: f = sps_pkg::SPS_PS_D0;
    endcase
    return f;
  endfunction

  // True in D1, D2 and D3hot
  function automatic logic is_low(input sps_pkg::sps_dstate_t st);
    return st == sps_pkg::SPS_D1 || st == sps_pkg::SPS_D2 ||
           st == sps_pkg::SPS_D3HOT;
  endfunction

  sps_pkg::sps_dstate_t dstate [NUM_PORTS];
  logic                 perst_s1;
  logic                 perst_s2;
  logic                 core_rst;
  logic                 turn_off_seen;
  logic [NUM_PORTS-1:0] low_ports;
  logic [NUM_PORTS-1:0] pme_cause;

  // Fundamental reset pin is asynchronous to the core clock
  always_ff @(posedge clock) begin
    if (rst) begin
      perst_s1 <= 1'b0;
      perst_s2 <= 1'b0;
    end else begin
      perst_s1 <= fundamental_reset_n;
      perst_s2 <= perst_s1;
    end
  end

  // Pin reset is folded into the core reset and held while low [R26]
  assign core_rst = rst | ~perst_s2;

  genvar i;
  generate
    for (i = 0; i < NUM_PORTS; i++) begin : g_port
      logic [1:0]                        wdata;
      logic [sps_pkg::SPS_CMD_W-1:0]     cmd;
      logic [sps_pkg::SPS_IDLE_CNT_W-1:0] idle_cnt;

      assign wdata = ps_wdata[2*i +: 2];
      assign cmd   = cmd_enables[sps_pkg::SPS_CMD_W*i +: sps_pkg::SPS_CMD_W];

      // Device state: moves only on reset or software action [R21]
      always_ff @(posedge clock) begin
        if (core_rst) begin
          dstate[i] <= sps_pkg::SPS_D0_UNINIT;                  // [R3]
        end else begin
          unique case (dstate[i])
            sps_pkg::SPS_D0_UNINIT,
            sps_pkg::SPS_D0_ACTIVE: begin
              if (ps_write[i] && wdata == sps_pkg::SPS_PS_D1) begin
                dstate[i] <= sps_pkg::SPS_D1;                   // [R1] [R23]
              end else if (ps_write[i] && wdata == sps_pkg::SPS_PS_D2) begin
                dstate[i] <= sps_pkg::SPS_D2;                   // [R1] [R23]
              end else if (ps_write[i] &&
                           wdata == sps_pkg::SPS_PS_D3HOT) begin
                dstate[i] <= sps_pkg::SPS_D3HOT;                // [R1] [R23]
              end else if (|cmd) begin
                dstate[i] <= sps_pkg::SPS_D0_ACTIVE;            // [R4]
              end
            end
            sps_pkg::SPS_D1,
            sps_pkg::SPS_D2: begin
              // Back to D0 keeps the port configured
              if (ps_write[i] && wdata == sps_pkg::SPS_PS_D0) begin
                dstate[i] <= sps_pkg::SPS_D0_ACTIVE;
              end
            end
            sps_pkg::SPS_D3HOT: begin
              if (ps_write[i] && wdata == sps_pkg::SPS_PS_D0) begin
                dstate[i] <= sps_pkg::SPS_D0_UNINIT;            // [R2]
              end
            end
          endcase
        end
      end

      // Hardware idle timer; only a D0 port may drop to L0s or L1
      always_ff @(posedge clock) begin
        if (core_rst || !aspm_enable[i] || !link_idle[i] ||
            is_low(dstate[i])) begin
          idle_cnt <= '0;
        end else if (idle_cnt != L1_CYC) begin
          idle_cnt <= idle_cnt + 1'b1;                          // [R22]
        end
      end

      assign aspm_l0s_req[i] = idle_cnt >= L0S_CYC;            // [R22]
      assign aspm_l1_req[i]  = idle_cnt == L1_CYC;             // [R22]
      assign ps_field[2*i +: 2] = ps_of(dstate[i]);            // [R23]
      assign d0_active[i]  = dstate[i] == sps_pkg::SPS_D0_ACTIVE;
      assign low_ports[i]  = is_low(dstate[i]);
    end
  endgenerate

  // Events only count for low-power ports with PME enabled
  assign pme_cause = (hot_plug_event | link_state_change) & low_ports &
                     pme_enable;                                // [R10] [R24]

  // Sticky PME status; a new event beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (core_rst) begin
      pme_status <= {NUM_PORTS{sps_pkg::SPS_PME_ST_RESET}};
      pme_pulse  <= 1'b0;
    end else begin
      pme_status <= (pme_status & ~pme_status_clr) | pme_cause;
      pme_pulse  <= |pme_cause;                                 // [R10]
    end
  end

  // Acceptance decision, one cycle after the request
  always_ff @(posedge clock) begin
    if (core_rst) begin
      resp_valid   <= 1'b0;
      resp_ur      <= 1'b0;
      resp_forward <= 1'b0;
    end else begin
      resp_valid   <= req_valid;
      resp_ur      <= 1'b0;
      resp_forward <= req_valid;                                // [R7]
      if (req_valid && low_ports[req_port] &&
          (req_kind == sps_pkg::SPS_REQ_MEM ||
           req_kind == sps_pkg::SPS_REQ_IO ||
           req_kind == sps_pkg::SPS_REQ_CFG1)) begin
        resp_ur      <= 1'b1;                                   // [R5] [R6]
        resp_forward <= 1'b0;
      end
    end
  end

  // Upstream link management; held quiet through core reset [R26]
  always_ff @(posedge clock) begin
    if (core_rst) begin
      up_l1_req     <= 1'b0;
      turn_off_fwd  <= 1'b0;
      turn_off_seen <= 1'b0;
    end else begin
      up_l1_req     <= low_ports[0] & ~turn_off_seen;          // [R8] [R9]
      turn_off_fwd  <= turn_off_rx;                             // [R11]
      if (turn_off_rx) begin
        turn_off_seen <= 1'b1;                                  // [R11]
      end
    end
  end

  assign up_l23_req   = turn_off_seen;                          // [R11]
  assign d3cold_ready = turn_off_seen & (&link_l23_ready);      // [R12]

  // Wake path lives on aux reset so core reset cannot silence it
  sps_wake_fwd #(
    .NUM_DOWN (NUM_PORTS - 1)
  ) u_wake (
    .clock           (clock),
    .aux_rst         (aux_rst),
    .main_power_good (main_power_good),
    .beacon_det      (beacon_det),
    .wake_n_i        (wake_n_i),
    .wake_n_o        (wake_n_o),
    .wake_n_oe       (wake_n_oe),
    .beacon_up       (beacon_up),
    .links_in_l2     (links_in_l2)
  );

  // Checks
  sequence s_low_req(sps_pkg::sps_req_t k);
    req_valid && low_ports[req_port] && req_kind == k;
  endsequence

  property p_mem_ur;
    @(posedge clock) disable iff (core_rst)
      s_low_req(sps_pkg::SPS_REQ_MEM) |=> resp_valid && resp_ur;
  endproperty
  a_mem_ur: assert property (p_mem_ur) // [R5]
    else $error("memory request to low-power port not UR");

  property p_cfg1_ur;
    @(posedge clock) disable iff (core_rst)
      s_low_req(sps_pkg::SPS_REQ_CFG1) |=> resp_ur && !resp_forward;
  endproperty
  a_cfg1_ur: assert property (p_cfg1_ur) // [R6]
    else $error("type 1 config to low-power port not UR");

  property p_never_ur;
    @(posedge clock) disable iff (core_rst)
      req_valid && (req_kind == sps_pkg::SPS_REQ_CFG0 ||
                    req_kind == sps_pkg::SPS_REQ_CPL)
      |=> resp_valid && resp_forward && !resp_ur;
  endproperty
  a_never_ur: assert property (p_never_ur) // [R5] [R7]
    else $error("config 0 or completion was refused");

  sequence s_d3_write;
    !low_ports[0] && ps_write[0] &&
    ps_wdata[1:0] == sps_pkg::SPS_PS_D3HOT;
  endsequence

  property p_d3_entry;
    @(posedge clock) disable iff (core_rst)
      s_d3_write |=> ps_field[1:0] == sps_pkg::SPS_PS_D3HOT
                 ##1 up_l1_req || turn_off_seen;
  endproperty
  a_d3_entry: assert property (p_d3_entry) // [R1] [R9]
    else $error("D3hot write did not enter D3hot and L1");

  property p_d3_exit;
    @(posedge clock) disable iff (core_rst)
      dstate[0] == sps_pkg::SPS_D3HOT && ps_write[0] &&
      ps_wdata[1:0] == sps_pkg::SPS_PS_D0
      |=> dstate[0] == sps_pkg::SPS_D0_UNINIT ##1 !up_l1_req;
  endproperty
  a_d3_exit: assert property (p_d3_exit) // [R2]
    else $error("D3hot exit did not reach D0 uninitialised");

  property p_perst_hold;
    @(posedge clock) disable iff (rst)
      !perst_s2 |=> ps_field == '0 && !up_l1_req && !turn_off_fwd &&
                    aspm_l0s_req == '0;
  endproperty
  a_perst_hold: assert property (p_perst_hold) // [R3] [R26]
    else $error("state moved during fundamental reset");

  property p_pme;
    @(posedge clock) disable iff (core_rst)
      |pme_cause |=> pme_pulse && ((pme_status & $past(pme_cause)) != '0);
  endproperty
  a_pme: assert property (p_pme) // [R10]
    else $error("PME not raised for low-power event");

  property p_pme_mask;
    @(posedge clock) disable iff (core_rst)
      pme_pulse |-> (($past(hot_plug_event) | $past(link_state_change)) &
                     $past(low_ports) & $past(pme_enable)) != '0;
  endproperty
  a_pme_mask: assert property (p_pme_mask) // [R24]
    else $error("PME raised while not enabled");

  property p_turn_off;
    @(posedge clock) disable iff (core_rst)
      turn_off_rx |=> turn_off_fwd ##1 !turn_off_fwd && up_l23_req;
  endproperty
  a_turn_off: assert property (p_turn_off) // [R11]
    else $error("turn-off not forwarded as one pulse");

  property p_d3c_ready;
    @(posedge clock) disable iff (core_rst)
      d3cold_ready |-> (&link_l23_ready) && up_l23_req;
  endproperty
  a_d3c_ready: assert property (p_d3c_ready) // [R12]
    else $error("D3cold ready before all links in L2/L3");

endmodule

// >>> verification/sps_host_model.sv
// Host and endpoint model on the far side of the power controller
`timescale 1ns/100ps
module sps_host_model #(
  parameter int HOLD_CYC = 50
) (
  input  wire logic       clock,
  input  wire logic       go_d3cold,
  input  wire logic       go_wake,
  input  wire logic       up_l23_req,
  input  wire logic       ep_wake_n,
  input  wire logic       wake_n_o,
  input  wire logic       wake_n_oe,
  output logic            turn_off_rx,
  output logic [3:0]      link_l23_ready,
  output logic            fundamental_reset_n,
  output logic            main_power_good,
  output logic            ref_clock_on,
  output wire logic       wake_n_i
);
  int n;

  // Shared wake line, pulled up, pulled low by either party
  assign wake_n_i = (wake_n_oe ? wake_n_o : 1'b1) & ep_wake_n;

  // Turn-off, power removal and wake-up sequence of the host
  initial begin
    turn_off_rx = 1'b0;
    link_l23_ready = 4'h0;
    fundamental_reset_n = 1'b1;
    main_power_good = 1'b1;
    ref_clock_on = 1'b1;
    forever begin
      @(posedge go_d3cold);
      @(posedge clock) #1 turn_off_rx = 1'b1;
      @(posedge clock) #1 turn_off_rx = 1'b0;
      n = 0;
      while (!up_l23_req && n < 20) begin
        @(posedge clock);
        n++;
      end
      // Links come up ready one by one, so readiness is seen partial
      for (int i = 0; i < 4; i++) begin
        repeat (4) @(posedge clock);
        #1 link_l23_ready[i] = 1'b1;
      end
      repeat (4) @(posedge clock);
      #1 fundamental_reset_n = 1'b0;
      repeat (2) @(posedge clock);
      #1 ref_clock_on = 1'b0;
      main_power_good = 1'b0;
      @(posedge go_wake);
      @(posedge clock) #1 main_power_good = 1'b1;
      ref_clock_on = 1'b1;
      link_l23_ready = 4'h0;
      // Hold shortened from the long power-up wait
      repeat (HOLD_CYC) @(posedge clock);
      #1 fundamental_reset_n = 1'b1;
    end
  end
endmodule

// >>> verification/switch_port_power_state_control_test.sv
// Self-checking bench of the port power-state controller
`timescale 1ns/100ps
module switch_port_power_state_control_test;
  localparam int N = 4;
  logic              clock, rst, aux_rst, go_d3cold, go_wake, ep_wake_n;
  logic [N-1:0]      ps_write, pme_enable, pme_status_clr, hot_plug_event;
  logic [N-1:0]      link_state_change, aspm_enable, link_idle;
  logic [2*N-1:0]    ps_wdata, ps_field;
  logic [3*N-1:0]    cmd_enables;
  logic              req_valid, turn_off_rx, main_power_good, wake_n_i;
  logic [1:0]        req_port, st;
  sps_pkg::sps_req_t req_kind;
  logic [N-1:0]      link_l23_ready, d0_active, aspm_l0s_req, aspm_l1_req;
  logic [N-1:0]      pme_status, ev;
  logic [N-2:0]      beacon_det;
  logic              fundamental_reset_n, pme_pulse, resp_valid, resp_ur;
  logic              resp_forward, up_l1_req, turn_off_fwd, up_l23_req;
  logic              d3cold_ready, wake_n_o, wake_n_oe, beacon_up;
  logic              links_in_l2, ref_clock_on;
  logic [1:0]        exp_q[$];
  int                miscompares = 0, tests_run = 0, cycles = 0, tf;

  sps_power_ctrl #(.NUM_PORTS(N), .PORT_W(2)) uut (
    .clock(clock), .rst(rst), .aux_rst(aux_rst),
    .fundamental_reset_n(fundamental_reset_n), .ps_write(ps_write),
    .ps_wdata(ps_wdata), .cmd_enables(cmd_enables),
    .pme_enable(pme_enable), .pme_status_clr(pme_status_clr),
    .hot_plug_event(hot_plug_event),
    .link_state_change(link_state_change), .req_valid(req_valid),
    .req_port(req_port), .req_kind(req_kind), .turn_off_rx(turn_off_rx),
    .link_l23_ready(link_l23_ready), .aspm_enable(aspm_enable),
    .link_idle(link_idle), .main_power_good(main_power_good),
    .beacon_det(beacon_det), .wake_n_i(wake_n_i), .ps_field(ps_field),
    .d0_active(d0_active), .pme_status(pme_status), .pme_pulse(pme_pulse),
    .resp_valid(resp_valid), .resp_ur(resp_ur),
    .resp_forward(resp_forward), .up_l1_req(up_l1_req),
    .turn_off_fwd(turn_off_fwd), .up_l23_req(up_l23_req),
    .d3cold_ready(d3cold_ready), .aspm_l0s_req(aspm_l0s_req),
    .aspm_l1_req(aspm_l1_req), .wake_n_o(wake_n_o),
    .wake_n_oe(wake_n_oe), .beacon_up(beacon_up),
    .links_in_l2(links_in_l2));

  sps_host_model #(.HOLD_CYC(50)) host (
    .clock(clock), .go_d3cold(go_d3cold), .go_wake(go_wake),
    .up_l23_req(up_l23_req), .ep_wake_n(ep_wake_n), .wake_n_o(wake_n_o),
    .wake_n_oe(wake_n_oe), .turn_off_rx(turn_off_rx),
    .link_l23_ready(link_l23_ready),
    .fundamental_reset_n(fundamental_reset_n),
    .main_power_good(main_power_good), .ref_clock_on(ref_clock_on),
    .wake_n_i(wake_n_i));

  // 50 MHz core clock
  initial clock = 1'b0;
  always #10 clock = ~clock;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Held strobe between calls, so back-to-back requests are legal
  task automatic req(input logic [1:0] p, input int k, input logic low);
    req_valid = 1'b1;
    req_port = p;
    req_kind = sps_pkg::sps_req_t'(k);
    if (low && k != 0 && k != 4) exp_q.push_back(2'h2);
    else exp_q.push_back(2'h1);
    @(posedge clock) #1;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Response watcher, sampled before the edge updates land
  always @(posedge clock) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(8'h1, 8'h0, "stray response");
      else check({6'h0, resp_ur, resp_forward}, {6'h0, exp_q.pop_front()},
                 "response");
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'hC8F49D18));
    {rst, aux_rst, go_d3cold, go_wake, ep_wake_n} = 5'h19;
    {ps_write, pme_enable, pme_status_clr, hot_plug_event} = 16'h0;
    {link_state_change, aspm_enable, link_idle} = 12'h0;
    {ps_wdata, cmd_enables, req_valid, req_port, beacon_det} = 26'h0;
    req_kind = sps_pkg::SPS_REQ_CFG0;
    step(3);
    rst = 1'b0;
    aux_rst = 1'b0;
    step(4);
    check(ps_field, 8'h00, "field after reset");
    check(d0_active, 8'h0, "uninit after reset");
    for (int i = 0; i < N; i++) cmd_enables[3*i+:3] = 3'($urandom_range(1, 7));
    step(1);
    check(d0_active, 8'hF, "enables give active");
    cmd_enables = '0;
    for (int k = 0; k < 5; k++) req(2'($urandom_range(0, 3)), k, 1'b0);
    req_valid = 1'b0;
    for (int s = 1; s < 4; s++) begin
      st = 2'(s);
      ps_wdata = {N{st}};
      ps_write = 4'hF;
      step(1);
      ps_write = 4'h0;
      check(ps_field, {N{st}}, "field write");
      step(1);
      check(up_l1_req, 8'h1, "upstream L1 entry");
      for (int k = 0; k < 5; k++) req(2'($urandom_range(0, 3)), k, 1'b1);
      req_valid = 1'b0;
      hot_plug_event = 4'(1 << $urandom_range(0, 3));
      step(1);
      hot_plug_event = 4'h0;
      check(pme_pulse, 8'h0, "event with enable clear");
      pme_enable = 4'hF;
      ev = 4'(1 << $urandom_range(0, 3));
      link_state_change = ev;
      step(1);
      check(pme_pulse, 8'h1, "event in low power");
      check(pme_status, ev, "status set");
      pme_status_clr = 4'hF;
      step(1);
      link_state_change = 4'h0;
      check(pme_status, ev, "set beats clear");
      step(1);
      pme_status_clr = 4'h0;
      check(pme_status, 8'h0, "status cleared");
      pme_enable = 4'h0;
      ps_wdata = 8'h00;
      ps_write = 4'hF;
      step(1);
      ps_write = 4'h0;
      check(d0_active, (s == 3) ? 8'h0 : 8'hF, "back to D0");
    end
    // Idle links step down by themselves after the thresholds
    aspm_enable = 4'hF;
    link_idle = 4'hF;
    step(sps_pkg::SPS_L0S_IDLE_CYC - 1);
    check(aspm_l0s_req, 8'h0, "early L0s");
    step(1);
    check({aspm_l0s_req, aspm_l1_req}, 8'hF0, "idle L0s");
    step(sps_pkg::SPS_L1_IDLE_CYC - sps_pkg::SPS_L0S_IDLE_CYC - 1);
    check(aspm_l1_req, 8'h0, "early L1");
    step(1);
    check({aspm_l0s_req, aspm_l1_req}, 8'hFF, "idle L0s L1");
    link_idle = 4'h0;
    step(2);
    check(aspm_l1_req, 8'h0, "traffic leaves L1");
    go_d3cold = 1'b1;
    tf = 0;
    for (int i = 0; i < 60 && fundamental_reset_n; i++) begin
      @(posedge clock);
      check(d3cold_ready, &link_l23_ready, "ready for D3cold");
      tf += turn_off_fwd;
    end
    check(8'(tf), 8'h1, "turn-off forwarded once");
    for (int i = 0; i < 10 && main_power_good; i++) step(1);
    step(4);
    check(links_in_l2, 8'h1, "links in L2");
    check(ps_field, 8'h00, "held in reset");
    check({fundamental_reset_n, ref_clock_on}, 8'h0, "clock off");
    beacon_det = 3'(1 << $urandom_range(0, 2));
    step(4);
    check(beacon_up, 8'h1, "beacon forwarded");
    check({wake_n_oe, wake_n_i}, 8'h2, "wake pulled low");
    beacon_det = 3'h0;
    step(6);
    check({beacon_up, wake_n_oe}, 8'h0, "beacon gone");
    ep_wake_n = 1'b0;
    step(4);
    check({beacon_up, wake_n_oe}, 8'h2, "wake to beacon");
    ep_wake_n = 1'b1;
    go_wake = 1'b1;
    for (int i = 0; i < 80 && !fundamental_reset_n; i++) step(1);
    step(4);
    check({links_in_l2, d0_active}, 8'h0, "awake uninit");
    print_verdict();
  end
endmodule
